// ### verilog/rosr_pkg.sv
package rosr_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ROSR_OFS_FORCE_CHG = 8'h1e;
  localparam logic [7:0] ROSR_OFS_RATE_SHD = 8'h1f;
  localparam logic [7:0] ROSR_OFS_SERA_SHD = 8'h20;
  localparam logic [7:0] ROSR_OFS_SERB_SHD = 8'h21;
  localparam logic [7:0] ROSR_OFS_DEV_KILL = 8'h22;
  localparam logic [7:0] ROSR_OFS_PIN_CFG = 8'h23;

  // Values after reset
  localparam logic [1:0] ROSR_RST_FORCE_CHG = 2'h1;
  localparam logic [7:0] ROSR_RST_DEV_KILL = 8'h00;
  localparam logic [7:0] ROSR_RST_PIN_CFG = 8'h01;
  localparam logic [7:0] ROSR_RST_SHADOW = 8'h00;

  // Readable-bit masks; reserved bits read as zero
  localparam logic [7:0] ROSR_MASK_RATE = 8'hdf;
  localparam logic [7:0] ROSR_MASK_FIFO = 8'hcf;
  localparam logic [7:0] ROSR_MASK_KILL = 8'hf9;
  localparam logic [7:0] ROSR_MASK_PIN_CFG = 8'h87;

  // Field positions of the device disable register
  localparam int ROSR_KILL_WP_BIT = 0;
  localparam int ROSR_KILL_DEV_LSB = 3;
  localparam int ROSR_KILL_DEV_MSB = 7;

  // Field positions of the pin configuration register
  localparam int ROSR_CFG_DIR_BIT = 0;
  localparam int ROSR_CFG_INV_BIT = 1;
  localparam int ROSR_CFG_ALT_BIT = 2;
  localparam int ROSR_CFG_ODRAIN_BIT = 7;

  // Lock pin configuration code that makes the disable register read-only
  localparam logic [1:0] ROSR_LOCK_CODE = 2'b01;

  // Index of each pin in the synchroniser vector
  localparam int ROSR_PIN_STEP = 0;
  localparam int ROSR_PIN_DS0 = 1;
  localparam int ROSR_PIN_DS1 = 2;
  localparam int ROSR_PIN_DISK_CHANGED_FLAG = 3;
  localparam int ROSR_PIN_WP = 4;
  localparam int ROSR_PIN_LOCK = 5;
  localparam int ROSR_PIN_JOY = 6;
  localparam int ROSR_NUM_PINS = 7;

  // State on the main-supply reset
  typedef struct packed {
    logic [ROSR_NUM_PINS-1:0] pin_meta;
    logic [ROSR_NUM_PINS-1:0] pin_sync;
    logic step_prev;
    logic [1:0] force_chg;
    logic [7:0] rate_shadow;
    logic [7:0] sera_shadow;
    logic [7:0] serb_shadow;
    logic [7:0] rdata;
    logic disk_changed_flag;
    logic wp_to_core;
    logic [4:0] dev_enable;
    logic pin_out;
    logic pin_oe;
    logic gpio_read;
    logic joy_button;
  } rosr_main_type;

  // State on the standby-supply reset
  typedef struct packed {
    logic [7:0] dev_kill;
    logic [7:0] pin_cfg;
  } rosr_stby_type;

endpackage : rosr_pkg

// ### verilog/rosr_regs.sv
`timescale 1ns/100ps
module rosr_regs
  import rosr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic STBY_RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic RATE_WR_I,
  input wire logic [7:0] RATE_DATA_I,
  input wire logic SERA_FCR_WR_I,
  input wire logic [7:0] SERA_FCR_DATA_I,
  input wire logic SERB_FCR_WR_I,
  input wire logic [7:0] SERB_FCR_DATA_I,
  input wire logic STEP_PULSE_N_I,
  input wire logic DRIVE_SELECT0_N_I,
  input wire logic DRIVE_SELECT1_N_I,
  input wire logic DISK_CHANGE_IN_N_I,
  input wire logic WRITE_PROTECT_N_I,
  input wire logic FORCE_WP_I,
  output logic DISK_CHANGED_FLAG_O,
  output logic WP_TO_CORE_O,
  input wire logic [4:0] ACTIVATE_I,
  output logic [4:0] DEV_ENABLE_O,
  input wire logic LOCK_PIN_I,
  input wire logic [1:0] LOCK_CFG_I,
  input wire logic JOYSTICK_BUTTON_PIN_I,
  input wire logic GPIO_DATA_I,
  output logic JOYSTICK_BUTTON_PIN_O,
  output logic JOYSTICK_BUTTON_PIN_OE_O,
  output logic GPIO_READ_O,
  output logic JOYSTICK1_BUTTON1_O
);

  rosr_main_type main_q;
  rosr_main_type next_main;
  rosr_stby_type stby_q;
  rosr_stby_type next_stby;

  logic [ROSR_NUM_PINS-1:0] pin_raw;
  logic step_pulse_n;
  logic drive_select0_n;
  logic drive_select1_n;
  logic disk_change_in_n;
  logic write_protect_n;
  logic lock_pin;
  logic joystick_button_pin;

  // Raw pins gathered for the synchroniser
  assign pin_raw[ROSR_PIN_STEP] = STEP_PULSE_N_I;
  assign pin_raw[ROSR_PIN_DS0] = DRIVE_SELECT0_N_I;
  assign pin_raw[ROSR_PIN_DS1] = DRIVE_SELECT1_N_I;
  assign pin_raw[ROSR_PIN_DISK_CHANGED_FLAG] = DISK_CHANGE_IN_N_I;
  assign pin_raw[ROSR_PIN_WP] = WRITE_PROTECT_N_I;
  assign pin_raw[ROSR_PIN_LOCK] = LOCK_PIN_I;
  assign pin_raw[ROSR_PIN_JOY] = JOYSTICK_BUTTON_PIN_I;

  // Synchronised pin levels, second flop only
  assign step_pulse_n = main_q.pin_sync[ROSR_PIN_STEP];
  assign drive_select0_n = main_q.pin_sync[ROSR_PIN_DS0];
  assign drive_select1_n = main_q.pin_sync[ROSR_PIN_DS1];
  assign disk_change_in_n = main_q.pin_sync[ROSR_PIN_DISK_CHANGED_FLAG];
  assign write_protect_n = main_q.pin_sync[ROSR_PIN_WP];
  assign lock_pin = main_q.pin_sync[ROSR_PIN_LOCK];
  assign joystick_button_pin = main_q.pin_sync[ROSR_PIN_JOY];

  // Next-state logic for both reset domains
  always_comb
  begin
    logic wr_kill_ok;
    logic step_edge;
    logic [1:0] chg_clear;
    logic [1:0] chg_set;
    logic [1:0] chg_now;
    logic [7:0] rd_mux;
    logic force_wp_sel;
    logic cfg_dir_in;
    logic cfg_inv;
    logic cfg_alt;
    logic cfg_odrain;
    logic drive_val;
    wr_kill_ok = 1'b0;
    step_edge = 1'b0;
    chg_clear = 2'b00;
    chg_set = 2'b00;
    chg_now = 2'b00;
    rd_mux = 8'h00;
    force_wp_sel = 1'b0;
    cfg_dir_in = 1'b0;
    cfg_inv = 1'b0;
    cfg_alt = 1'b0;
    cfg_odrain = 1'b0;
    drive_val = 1'b0;
    next_main = main_q;
    next_stby = stby_q;

    // Two-flop synchronisers on all pins
    next_main.pin_meta = pin_raw;
    next_main.pin_sync = main_q.pin_meta;
    next_main.step_prev = step_pulse_n;

    // Forced change: step assertion clears selected drive's bit
    step_edge = main_q.step_prev & ~step_pulse_n;
    chg_clear[0] = step_edge & ~drive_select0_n;
    chg_clear[1] = step_edge & ~drive_select1_n;
    if (WR_I && ADDR_I == ROSR_OFS_FORCE_CHG)
    begin
      chg_set = WDATA_I[1:0];
    end
    // Set wins over clear; a written 0 changes nothing
    chg_now = (main_q.force_chg & ~chg_clear) | chg_set;
    next_main.force_chg = chg_now;

    // Shadows follow the source registers' writes
    if (RATE_WR_I)
    begin
      next_main.rate_shadow = RATE_DATA_I & ROSR_MASK_RATE;
    end
    if (SERA_FCR_WR_I)
    begin
      next_main.sera_shadow = SERA_FCR_DATA_I & ROSR_MASK_FIFO;
    end
    if (SERB_FCR_WR_I)
    begin
      next_main.serb_shadow = SERB_FCR_DATA_I & ROSR_MASK_FIFO;
    end

    // Disable register locks under the lock pin
    wr_kill_ok = !((LOCK_CFG_I == ROSR_LOCK_CODE) && lock_pin);
    if (WR_I && ADDR_I == ROSR_OFS_DEV_KILL && wr_kill_ok)
    begin
      next_stby.dev_kill = WDATA_I & ROSR_MASK_KILL;
    end

    // Pin configuration, reserved bits not stored
    if (WR_I && ADDR_I == ROSR_OFS_PIN_CFG)
    begin
      next_stby.pin_cfg = WDATA_I & ROSR_MASK_PIN_CFG;
    end

    // Read mux; shadows are read-only and unmapped reads zero
    unique case (ADDR_I)
      ROSR_OFS_FORCE_CHG: rd_mux = {6'h00, main_q.force_chg};
      ROSR_OFS_RATE_SHD: rd_mux = main_q.rate_shadow;
      ROSR_OFS_SERA_SHD: rd_mux = main_q.sera_shadow;
      ROSR_OFS_SERB_SHD: rd_mux = main_q.serb_shadow;
      ROSR_OFS_DEV_KILL: rd_mux = stby_q.dev_kill;
      ROSR_OFS_PIN_CFG: rd_mux = stby_q.pin_cfg;
      default: rd_mux = 8'h00;
    endcase
    // Read data stands only in the cycle after the strobe
    next_main.rdata = RD_I ? rd_mux : 8'h00;

    // Disk changed flag seen by the floppy core
    next_main.disk_changed_flag = (~drive_select0_n & main_q.force_chg[0])
      | (~drive_select1_n & main_q.force_chg[1])
      | ~disk_change_in_n;

    // Write protect indication to the floppy core
    force_wp_sel = (~drive_select0_n & FORCE_WP_I)
      | (~drive_select1_n & FORCE_WP_I);
    next_main.wp_to_core = force_wp_sel | ~write_protect_n
      | stby_q.dev_kill[ROSR_KILL_WP_BIT];

    // Disable bits override the activate bits
    next_main.dev_enable = ACTIVATE_I
      & ~stby_q.dev_kill[ROSR_KILL_DEV_MSB:ROSR_KILL_DEV_LSB];

    // Pin direction, polarity, function and driver type
    cfg_dir_in = stby_q.pin_cfg[ROSR_CFG_DIR_BIT];
    cfg_inv = stby_q.pin_cfg[ROSR_CFG_INV_BIT];
    cfg_alt = stby_q.pin_cfg[ROSR_CFG_ALT_BIT];
    cfg_odrain = stby_q.pin_cfg[ROSR_CFG_ODRAIN_BIT];
    drive_val = GPIO_DATA_I ^ cfg_inv;
    next_main.gpio_read = joystick_button_pin ^ cfg_inv;
    next_main.joy_button = cfg_alt ? joystick_button_pin : 1'b1;
    next_main.pin_out = cfg_odrain ? 1'b0 : drive_val;
    if (cfg_dir_in || cfg_alt)
    begin
      next_main.pin_oe = 1'b0;
    end
    else if (cfg_odrain)
    begin
      next_main.pin_oe = ~drive_val;
    end
    else
    begin
      next_main.pin_oe = 1'b1;
    end
  end

  // Main-supply reset domain
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      main_q.pin_meta <= '1;
      main_q.pin_sync <= '1;
      main_q.step_prev <= 1'b1;
      main_q.force_chg <= ROSR_RST_FORCE_CHG;
      main_q.rate_shadow <= ROSR_RST_SHADOW;
      main_q.sera_shadow <= ROSR_RST_SHADOW;
      main_q.serb_shadow <= ROSR_RST_SHADOW;
      main_q.rdata <= 8'h00;
      main_q.disk_changed_flag <= 1'b0;
      main_q.wp_to_core <= 1'b0;
      main_q.dev_enable <= 5'h00;
      main_q.pin_out <= 1'b0;
      main_q.pin_oe <= 1'b0;
      main_q.gpio_read <= 1'b0;
      main_q.joy_button <= 1'b1;
    end
    else
    begin
      main_q <= next_main;
    end
  end

  // Standby-supply reset domain
  always_ff @(posedge MCLK_I or negedge STBY_RST_B_I)
  begin
    if (!STBY_RST_B_I)
    begin
      stby_q.dev_kill <= ROSR_RST_DEV_KILL;
      stby_q.pin_cfg <= ROSR_RST_PIN_CFG;
    end
    else
    begin
      stby_q <= next_stby;
    end
  end

  // Outputs straight from flops
  assign RDATA_O = main_q.rdata;
  assign DISK_CHANGED_FLAG_O = main_q.disk_changed_flag;
  assign WP_TO_CORE_O = main_q.wp_to_core;
  assign DEV_ENABLE_O = main_q.dev_enable;
  assign JOYSTICK_BUTTON_PIN_O = main_q.pin_out;
  assign JOYSTICK_BUTTON_PIN_OE_O = main_q.pin_oe;
  assign GPIO_READ_O = main_q.gpio_read;
  assign JOYSTICK1_BUTTON1_O = main_q.joy_button;

endmodule : rosr_regs

// ### dv/rosr_regs_asserts.sv
`timescale 1ns/100ps
module rosr_regs_asserts (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic RATE_WR_I,
  input wire logic [7:0] RATE_DATA_I,
  input wire logic SERA_FCR_WR_I,
  input wire logic [7:0] SERA_FCR_DATA_I,
  input wire logic DISK_CHANGE_IN_N_I,
  input wire logic WRITE_PROTECT_N_I,
  input wire logic DISK_CHANGED_FLAG_O,
  input wire logic WP_TO_CORE_O,
  input wire logic [4:0] ACTIVATE_I,
  input wire logic [4:0] DEV_ENABLE_O
);
  // Main clock, quiet while main reset holds
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);
  // Read-back of reserved bits and of set bits
  a_force_rsvd:
    assert property (RD_I && ADDR_I == 8'h1e |=> RDATA_O[7:2] == 6'h00)
    else $error("force change reserved bits set");
  a_kill_rsvd:
    assert property (RD_I && ADDR_I == 8'h22 |=> RDATA_O[2:1] == 2'h0)
    else $error("disable reserved bits set");
  a_force_set:
    assert property (WR_I && ADDR_I == 8'h1e && WDATA_I[0] ##2 RD_I && ADDR_I == 8'h1e
      |=> RDATA_O[0]) else $error("forced change bit not set");
  // Shadows follow their source writes
  a_rate_track:
    assert property ($past(RATE_WR_I, 2) && !$past(RATE_WR_I) && !RATE_WR_I && RD_I
      && ADDR_I == 8'h1f |=> RDATA_O == ($past(RATE_DATA_I, 3) & 8'hdf))
    else $error("rate shadow wrong");
  a_sera_track:
    assert property ($past(SERA_FCR_WR_I, 2) && !$past(SERA_FCR_WR_I) && !SERA_FCR_WR_I && RD_I
      && ADDR_I == 8'h20 |=> RDATA_O == ($past(SERA_FCR_DATA_I, 3) & 8'hcf))
    else $error("serial A shadow wrong");
  // Outputs towards the cores
  a_dev_enable:
    assert property ((DEV_ENABLE_O & ~$past(ACTIVATE_I)) == 5'h00)
    else $error("device enabled without activate");
  a_wp_pin:
    assert property (!WRITE_PROTECT_N_I [*4] |-> WP_TO_CORE_O)
    else $error("write protect pin not passed on");
  a_chg_pin:
    assert property (!DISK_CHANGE_IN_N_I [*4] |-> DISK_CHANGED_FLAG_O)
    else $error("disk change pin not passed on");
endmodule : rosr_regs_asserts

bind rosr_regs rosr_regs_asserts u_rosr_regs_asserts (
  .MCLK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .RATE_WR_I, .RATE_DATA_I,
  .SERA_FCR_WR_I, .SERA_FCR_DATA_I, .DISK_CHANGE_IN_N_I, .WRITE_PROTECT_N_I,
  .DISK_CHANGED_FLAG_O, .WP_TO_CORE_O, .ACTIVATE_I, .DEV_ENABLE_O
);

// ### dv/tb_runtime_override_shadow_regs.sv
`timescale 1ns/100ps
module tb_runtime_override_shadow_regs;
  logic clk, rst_b, stby_b, wr, rd, r_wr, a_wr, b_wr, step_n, ds0_n, ds1_n, chg_n, wp_n;
  logic fwp, lock_pin, joy_in, gpio_d, dsk_o, wp_o, pin_o, pin_oe, gpio_rd, joy_o;
  logic [7:0] addr, wdata, rdata, sd;
  logic [4:0] dev_en, act;
  logic [1:0] lock_cfg;
  int n_fail, checks_done, cyc;
  rosr_regs u_rosr_regs (
    .MCLK_I(clk), .RST_B_I(rst_b), .STBY_RST_B_I(stby_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RATE_WR_I(r_wr), .RATE_DATA_I(sd),
    .SERA_FCR_WR_I(a_wr), .SERA_FCR_DATA_I(sd), .SERB_FCR_WR_I(b_wr), .SERB_FCR_DATA_I(sd),
    .STEP_PULSE_N_I(step_n), .DRIVE_SELECT0_N_I(ds0_n), .DRIVE_SELECT1_N_I(ds1_n),
    .DISK_CHANGE_IN_N_I(chg_n), .WRITE_PROTECT_N_I(wp_n), .FORCE_WP_I(fwp),
    .DISK_CHANGED_FLAG_O(dsk_o), .WP_TO_CORE_O(wp_o), .ACTIVATE_I(act), .DEV_ENABLE_O(dev_en),
    .LOCK_PIN_I(lock_pin), .LOCK_CFG_I(lock_cfg), .JOYSTICK_BUTTON_PIN_I(joy_in),
    .GPIO_DATA_I(gpio_d), .JOYSTICK_BUTTON_PIN_O(pin_o), .JOYSTICK_BUTTON_PIN_OE_O(pin_oe),
    .GPIO_READ_O(gpio_rd), .JOYSTICK1_BUTTON1_O(joy_o));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic ck1(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask : ck1
  // Waits whole cycles, then steps off the edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr8
  // Read and compare in one go
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rdc
  // Source-register write strobes for the shadows
  task automatic sh(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    {b_wr, a_wr, r_wr} <= s;
    sd <= d;
    @(posedge clk);
    {b_wr, a_wr, r_wr} <= 3'h0;
  endtask : sh
  task automatic t_floppy();
    rdc(8'h1e, 8'h01);
    rdc(8'h24, 8'h00);
    wr8(8'h1e, 8'h00);
    rdc(8'h1e, 8'h01);
    wr8(8'h1e, 8'hff);
    rdc(8'h1e, 8'h03);
    ck1(dsk_o, 1'b0);
    @(posedge clk);
    ds0_n <= 1'b0;
    w(4);
    ck1(dsk_o, 1'b1);
    @(posedge clk);
    step_n <= 1'b0;
    repeat (2) @(posedge clk);
    step_n <= 1'b1;
    w(4);
    ck1(dsk_o, 1'b0);
    rdc(8'h1e, 8'h02);
    @(posedge clk);
    ds0_n <= 1'b1;
    ds1_n <= 1'b0;
    w(4);
    ck1(dsk_o, 1'b1);
    $display("floppy test done");
  endtask : t_floppy
  task automatic t_shadow();
    sh(3'h1, 8'hff);
    rdc(8'h1f, 8'hdf);
    sh(3'h2, 8'hff);
    rdc(8'h20, 8'hcf);
    sh(3'h4, 8'h5a);
    rdc(8'h21, 8'h4a);
    wr8(8'h21, 8'h00);
    rdc(8'h21, 8'h4a);
    sh(3'h1, 8'h21);
    rdc(8'h1f, 8'h01);
    $display("shadow test done");
  endtask : t_shadow
  task automatic t_kill();
    rdc(8'h22, 8'h00);
    wr8(8'h22, 8'hff);
    rdc(8'h22, 8'hf9);
    chk({3'h0, dev_en}, 8'h00);
    ck1(wp_o, 1'b1);
    wr8(8'h22, 8'ha8);
    w(3);
    chk({3'h0, dev_en}, 8'h0a);
    ck1(wp_o, 1'b0);
    @(posedge clk);
    act <= 5'h13;
    w(3);
    chk({3'h0, dev_en}, 8'h02);
    @(posedge clk);
    act <= 5'h1f;
    fwp <= 1'b1;
    wp_n <= 1'b0;
    w(4);
    ck1(wp_o, 1'b1);
    @(posedge clk);
    wp_n <= 1'b1;
    lock_cfg <= 2'h1;
    lock_pin <= 1'b1;
    w(4);
    wr8(8'h22, 8'h00);
    rdc(8'h22, 8'ha8);
    @(posedge clk);
    lock_pin <= 1'b0;
    w(4);
    wr8(8'h22, 8'h00);
    rdc(8'h22, 8'h00);
    $display("disable test done");
  endtask : t_kill
  task automatic t_pin();
    rdc(8'h23, 8'h01);
    ck1(pin_oe, 1'b0);
    wr8(8'h23, 8'h00);
    w(3);
    ck1(pin_oe, 1'b1);
    ck1(pin_o, 1'b1);
    wr8(8'h23, 8'h82);
    w(3);
    ck1(pin_oe, 1'b1);
    ck1(pin_o, 1'b0);
    wr8(8'h23, 8'h80);
    w(3);
    ck1(pin_oe, 1'b0);
    @(posedge clk);
    joy_in <= 1'b0;
    wr8(8'h23, 8'h07);
    w(4);
    ck1(joy_o, 1'b0);
    ck1(gpio_rd, 1'b1);
    wr8(8'h23, 8'hff);
    rdc(8'h23, 8'h87);
    $display("pin test done");
  endtask : t_pin
  // Mid-run resets: main reset leaves the standby registers, standby reset returns its own to their reset values
  task automatic t_reset();
    wr8(8'h22, 8'ha8);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdc(8'h1e, 8'h01);
    rdc(8'h22, 8'ha8);
    rdc(8'h23, 8'h87);
    @(posedge clk);
    stby_b <= 1'b0;
    repeat (2) @(posedge clk);
    stby_b <= 1'b1;
    rdc(8'h22, 8'h00);
    rdc(8'h23, 8'h01);
    $display("reset test done");
  endtask : t_reset
  // Main sequence
  initial
  begin
    {rst_b, stby_b, wr, rd, r_wr, a_wr, b_wr, fwp, lock_pin} = 9'h000;
    {step_n, ds0_n, ds1_n, chg_n, wp_n, joy_in, gpio_d} = 7'h7f;
    {addr, wdata, sd, lock_cfg} = 26'h0000000;
    {n_fail, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
    act = 5'h1f;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    stby_b <= 1'b1;
    t_floppy();
    t_shadow();
    t_kill();
    t_pin();
    t_reset();
    close_out();
  end
endmodule : tb_runtime_override_shadow_regs
